// ### design/crm_core.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module crm_core
  import crm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt request pin, active high level
  input wire logic irq_req
);
  // ==========================================================
  // Elaboration check
  if (ADDR_W < 8) begin : g_bad_addr
    $error("crm_core: ADDR_W must be at least 8");
  end

  // ==========================================================
  // State
  crm_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] h_q, h_d;
  logic [7:0] x_q, x_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] ccr_q, ccr_d;
  logic [15:0] ea_q, ea_d;
  logic inhibit_q, inhibit_d;
  logic [31:0] cmd_q;
  logic cmd_pend_q;
  logic [31:0] vec_q;
  logic [23:0] trace_q;
  logic irq_meta_q, irq_sync_q;
  // Bus side state
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q, w_got_q;

  // ==========================================================
  // Command fields and sequencing conditions
  wire [7:0] op = cmd_q[7:0];
  wire [7:0] arg8 = cmd_q[15:8];
  wire [15:0] arg16 = cmd_q[23:8];
  wire [15:0] arg_sext = {{8{arg8[7]}}, arg8};
  wire [15:0] hx = {h_q, x_q};
  wire idle = (state_q == CRM_S_IDLE);
  // Mask and one-boundary shadow both hold interrupts back
  wire take_irq = idle && irq_sync_q && !ccr_q[CRM_CC_I] && !inhibit_q;
  wire exec = idle && cmd_pend_q && !take_irq;
  wire signed_lt = ccr_q[CRM_CC_N] ^ ccr_q[CRM_CC_V];
  wire cin = (op == CRM_OP_ADC) ? ccr_q[CRM_CC_C] : 1'b0;

  // Fetch length of each command in bytes
  wire len3 = (op == CRM_OP_LDHX) || (op == CRM_OP_JMP);
  wire len2 = (op == CRM_OP_LDA) || (op == CRM_OP_LDX) || (op == CRM_OP_ADD)
    || (op == CRM_OP_ADC) || (op == CRM_OP_SUB) || (op == CRM_OP_ADD_STK)
    || (op == CRM_OP_TAP) || (op == CRM_OP_BRA) || (op == CRM_OP_BLT)
    || (op == CRM_OP_BGE) || (op == CRM_OP_EA_DIR) || (op == CRM_OP_EA_IX1);
  wire [15:0] op_len = len3 ? 16'h0003 : (len2 ? 16'h0002 : 16'h0001);
  wire [15:0] pc_seq = pc_q + op_len;

  // Byte pushed in each interrupt stacking step
  wire [7:0] push_byte = (cnt_q == 3'h0) ? pc_q[7:0] :
                         (cnt_q == 3'h1) ? pc_q[15:8] :
                         (cnt_q == 3'h2) ? x_q :
                         (cnt_q == 3'h3) ? acc_q : ccr_q;

  // ==========================================================
  // Register updates from commands and sequences
  logic [7:0] res;
  logic upd_nz;
  logic [8:0] sum;
  logic [4:0] hsum;
  always_comb begin
    acc_d = acc_q;
    h_d = h_q;
    x_d = x_q;
    sp_d = sp_q;
    pc_d = pc_q;
    ccr_d = ccr_q;
    ea_d = ea_q;
    inhibit_d = inhibit_q;
    res = 8'h00;
    upd_nz = 1'b0;
    sum = 9'h000;
    hsum = 5'h00;
    if (exec) begin
      inhibit_d = 1'b0; // Shadow lasts one instruction only
      pc_d = pc_seq;
      case (op)
        CRM_OP_LDA: begin
          acc_d = arg8;
          res = arg8;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = 1'b0;
        end
        CRM_OP_LDX: begin
          x_d = arg8;
          res = arg8;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = 1'b0;
        end
        CRM_OP_LDHX: begin
          h_d = arg16[15:8];
          x_d = arg16[7:0];
          ccr_d[CRM_CC_N] = arg16[15];
          ccr_d[CRM_CC_Z] = (arg16 == 16'h0000);
          ccr_d[CRM_CC_V] = 1'b0;
        end
        CRM_OP_STA: begin
          res = acc_q; // Store flags follow the stored byte
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = 1'b0;
        end
        CRM_OP_TAX: x_d = acc_q;
        CRM_OP_TXA: acc_d = x_q;
        CRM_OP_CLRX: begin
          x_d = 8'h00;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = 1'b0;
        end
        CRM_OP_INCX: begin
          res = x_q + 8'h01;
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = (x_q == 8'h7F);
        end
        CRM_OP_DECX: begin
          res = x_q - 8'h01;
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = (x_q == 8'h80);
        end
        CRM_OP_COMX: begin
          res = ~x_q;
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = 1'b0;
          ccr_d[CRM_CC_C] = 1'b1;
        end
        CRM_OP_NEGX: begin
          res = 8'h00 - x_q;
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_V] = (res == 8'h80);
          ccr_d[CRM_CC_C] = (res != 8'h00);
        end
        CRM_OP_ASLX, CRM_OP_ROLX: begin
          res = {x_q[6:0], (op == CRM_OP_ROLX) & ccr_q[CRM_CC_C]};
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_C] = x_q[7];
          ccr_d[CRM_CC_V] = res[7] ^ x_q[7];
        end
        CRM_OP_LSRX, CRM_OP_RORX: begin
          res = {(op == CRM_OP_RORX) & ccr_q[CRM_CC_C], x_q[7:1]};
          x_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_C] = x_q[0];
          ccr_d[CRM_CC_V] = res[7] ^ x_q[0];
        end
        CRM_OP_ADD, CRM_OP_ADC: begin
          sum = {1'b0, acc_q} + {1'b0, arg8} + {8'h00, cin};
          hsum = {1'b0, acc_q[3:0]} + {1'b0, arg8[3:0]} + {4'h0, cin};
          res = sum[7:0];
          acc_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_H] = hsum[4];
          ccr_d[CRM_CC_C] = sum[8];
          ccr_d[CRM_CC_V] = (acc_q[7] == arg8[7]) && (res[7] != acc_q[7]);
        end
        CRM_OP_SUB: begin
          sum = {1'b0, acc_q} - {1'b0, arg8};
          res = sum[7:0];
          acc_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_C] = sum[8];
          ccr_d[CRM_CC_V] = (acc_q[7] != arg8[7]) && (res[7] != acc_q[7]);
        end
        CRM_OP_DEC_ADJ: begin
          // Correction valid only right after a packed decimal add
          res = acc_q
            + ((ccr_q[CRM_CC_H] || (acc_q[3:0] > CRM_BCD_DIGIT_MAX)) ? CRM_BCD_LO_FIX : 8'h00)
            + ((ccr_q[CRM_CC_C] || (acc_q > CRM_BCD_BYTE_MAX)) ? CRM_BCD_HI_FIX : 8'h00);
          acc_d = res;
          upd_nz = 1'b1;
          ccr_d[CRM_CC_C] = ccr_q[CRM_CC_C] || (acc_q > CRM_BCD_BYTE_MAX);
        end
        CRM_OP_ADD_STK: sp_d = sp_q + arg_sext;
        CRM_OP_STK_LOW: sp_d[7:0] = CRM_SP_LOW_RST;
        CRM_OP_MASK_CLR: begin
          ccr_d[CRM_CC_I] = 1'b0;
          inhibit_d = ccr_q[CRM_CC_I];
        end
        CRM_OP_SEI: ccr_d[CRM_CC_I] = 1'b1;
        CRM_OP_TAP: begin
          ccr_d = arg8;
          inhibit_d = ccr_q[CRM_CC_I] && !arg8[CRM_CC_I];
        end
        CRM_OP_JMP: pc_d = arg16;
        CRM_OP_BRA: pc_d = pc_seq + arg_sext;
        CRM_OP_BLT: pc_d = signed_lt ? pc_seq + arg_sext : pc_seq;
        CRM_OP_BGE: pc_d = signed_lt ? pc_seq : pc_seq + arg_sext;
        CRM_OP_EA_DIR: ea_d = {CRM_DIR_PAGE, arg8};
        CRM_OP_EA_IX: ea_d = hx;
        CRM_OP_EA_IX1: ea_d = hx + {8'h00, arg8};
        CRM_OP_EA_IXP: begin
          ea_d = hx;
          {h_d, x_d} = hx + 16'h0001;
        end
        default: ;
      endcase
      if (upd_nz) begin
        ccr_d[CRM_CC_N] = res[7];
        ccr_d[CRM_CC_Z] = (res == 8'h00);
      end
    end else if (state_q == CRM_S_PUSH) begin
      sp_d = sp_q - 16'h0001;
    end else if (state_q == CRM_S_VEC) begin
      ccr_d[CRM_CC_I] = 1'b1;
      pc_d = vec_q[31:16];
    end else if ((state_q == CRM_S_RESET) && (cnt_q == CRM_RESET_SEQ_CYC - 3'h1)) begin
      pc_d = vec_q[15:0];
    end
    ccr_d = ccr_d | CRM_CCR_ONES;
  end

  // ==========================================================
  // Sequencer: reset vector fetch, stacking, vectoring
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      CRM_S_RESET: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CRM_RESET_SEQ_CYC - 3'h1) begin
          state_d = CRM_S_IDLE;
          cnt_d = 3'h0;
        end
      end
      CRM_S_IDLE: begin
        if (take_irq) begin
          state_d = CRM_S_PUSH;
        end
      end
      CRM_S_PUSH: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CRM_PUSH_BYTES - 3'h1) begin
          state_d = CRM_S_VEC;
          cnt_d = 3'h0;
        end
      end
      CRM_S_VEC: state_d = CRM_S_IDLE;
      default: state_d = CRM_S_RESET;
    endcase
  end

  // Data registers keep their contents across reset
  always_ff @(posedge aclk) begin
    acc_q <= acc_d;
    x_q <= x_d;
  end

  // Control and pointer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CRM_S_RESET;
      cnt_q <= 3'h0;
      h_q <= CRM_H_RST;
      sp_q <= CRM_SP_RST;
      pc_q <= 16'h0000;
      ccr_q <= CRM_CCR_RST;
      ea_q <= 16'h0000;
      inhibit_q <= 1'b0;
      trace_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      h_q <= h_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      ccr_q <= ccr_d;
      ea_q <= ea_d;
      inhibit_q <= inhibit_d;
      if (state_q == CRM_S_PUSH) begin
        trace_q <= {sp_q, push_byte};
      end
    end
  end

  // Request pin passes two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_req;
      irq_sync_q <= irq_meta_q;
    end
  end

  // ==========================================================
  // AXI4-Lite slave; the CPU registers sit only on this port,
  // never in the address space that ea_q forms
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire do_write = aw_got_q && w_got_q && !bvalid;
  wire b_done = bvalid && bready;
  wire aw_got_d = aw_hs || (aw_got_q && !do_write);
  wire w_got_d = w_hs || (w_got_q && !do_write);
  wire bvalid_d = do_write || (bvalid && !b_done);
  wire wr_cmd = (awaddr_q == ADDR_W'(CRM_OFF_CMD));
  wire wr_vec = (awaddr_q == ADDR_W'(CRM_OFF_VECTORS));
  // A second command while one waits is refused, not queued
  wire wr_ok = (wr_cmd && !cmd_pend_q) || wr_vec;
  wire [31:0] wr_old = wr_cmd ? cmd_q : vec_q;
  wire [31:0] wr_new;
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wr_new[8*b+7:8*b] = wstrb_q[b] ? wdata_q[8*b+7:8*b] : wr_old[8*b+7:8*b];
  end

  // Read decode
  wire [7:0] ra = araddr[7:0];
  wire ra_hi_zero = ((araddr >> 8) == '0);
  wire [31:0] rd_status = {29'h0, inhibit_q, cmd_pend_q, !idle};
  wire [31:0] rd_val =
    (ra == CRM_OFF_CMD) ? cmd_q :
    (ra == CRM_OFF_ACC) ? {24'h0, acc_q} :
    (ra == CRM_OFF_INDEX) ? {16'h0, hx} :
    (ra == CRM_OFF_SP) ? {16'h0, sp_q} :
    (ra == CRM_OFF_PC) ? {16'h0, pc_q} :
    (ra == CRM_OFF_CCR) ? {24'h0, ccr_q | CRM_CCR_ONES} :
    (ra == CRM_OFF_STATUS) ? rd_status :
    (ra == CRM_OFF_VECTORS) ? vec_q :
    (ra == CRM_OFF_TRACE) ? {8'h0, trace_q} :
    (ra == CRM_OFF_EA) ? {16'h0, ea_q} : 32'h0;
  wire rd_hit = ra_hi_zero && (ra[1:0] == 2'h0) && (ra <= CRM_OFF_EA);

  // Write channels and software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= CRM_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      cmd_q <= 32'h0;
      cmd_pend_q <= 1'b0;
      vec_q <= CRM_VEC_RST;
    end else begin
      awready <= !aw_got_d && !bvalid_d;
      wready <= !w_got_d && !bvalid_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid <= bvalid_d;
      if (aw_hs) begin
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bresp <= wr_ok ? CRM_RESP_OKAY : CRM_RESP_SLVERR;
      end
      if (do_write && wr_ok && wr_cmd) begin
        cmd_q <= wr_new;
      end
      if (do_write && wr_ok && wr_vec) begin
        vec_q <= wr_new;
      end
      // Pending flag: raised by the bus, dropped when executed
      if (do_write && wr_ok && wr_cmd) begin
        cmd_pend_q <= 1'b1;
      end else if (exec) begin
        cmd_pend_q <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= CRM_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_val : 32'h0;
      rresp <= rd_hit ? CRM_RESP_OKAY : CRM_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule : crm_core
`default_nettype wire

// ### pkg/crm_pkg.sv
// Notes on behaviour
// - Eight-bit accumulator, untouched by reset
// - Index pointer is index_high:index_low, sixteen bits
// - Reset clears index_high, keeps index_low
// - index_low works as second data register
// - Sixteen-bit stack pointer addresses next free byte
// - Add-to-stack adds sign-extended byte to pointer
// - Reset loads stack pointer with 0x00FF
// - Stack-low reset touches low byte only
// - Program counter steps past each fetched byte
// - Change of flow loads a target address
// - After reset, counter takes the reset vector
// - Condition bits 6 and 5 always one
// - Overflow bit 7 from two's complement overflow
// - Half-carry bit 4 from bit 3 carry
// - Decimal adjust corrects sum using half-carry, carry
// - Mask bit 3 blocks interrupts, set after stacking
// - No interrupt right after mask is cleared
// - Negative bit 2 copies result bit 7
// - Zero bit 1 set on all-zero result
// - Carry bit 0 from carry, borrow, shifts
// - CPU registers lie outside the memory map
// - Direct mode reaches only the first page
// - Interrupt pushes pc low, high, index_low, acc, flags
// - Six cycles of vector fetch after reset
`default_nettype none
package crm_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] CRM_OFF_CMD = 8'h00;
  localparam logic [7:0] CRM_OFF_ACC = 8'h04;
  localparam logic [7:0] CRM_OFF_INDEX = 8'h08;
  localparam logic [7:0] CRM_OFF_SP = 8'h0C;
  localparam logic [7:0] CRM_OFF_PC = 8'h10;
  localparam logic [7:0] CRM_OFF_CCR = 8'h14;
  localparam logic [7:0] CRM_OFF_STATUS = 8'h18;
  localparam logic [7:0] CRM_OFF_VECTORS = 8'h1C;
  localparam logic [7:0] CRM_OFF_TRACE = 8'h20;
  localparam logic [7:0] CRM_OFF_EA = 8'h24;
  localparam logic [1:0] CRM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CRM_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Condition code layout and reset values
  localparam int unsigned CRM_CC_V = 7;
  localparam int unsigned CRM_CC_H = 4;
  localparam int unsigned CRM_CC_I = 3;
  localparam int unsigned CRM_CC_N = 2;
  localparam int unsigned CRM_CC_Z = 1;
  localparam int unsigned CRM_CC_C = 0;
  localparam logic [7:0] CRM_CCR_ONES = 8'h60;
  localparam logic [7:0] CRM_CCR_RST = 8'h68;
  localparam logic [7:0] CRM_H_RST = 8'h00;
  localparam logic [15:0] CRM_SP_RST = 16'h00FF;
  localparam logic [7:0] CRM_SP_LOW_RST = 8'hFF;
  localparam logic [31:0] CRM_VEC_RST = 32'h0000_0000;
  localparam logic [7:0] CRM_DIR_PAGE = 8'h00;
  localparam logic [7:0] CRM_BCD_LO_FIX = 8'h06;
  localparam logic [7:0] CRM_BCD_HI_FIX = 8'h60;
  localparam logic [3:0] CRM_BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] CRM_BCD_BYTE_MAX = 8'h99;
  // ==========================================================
  // Sequencing counts and status bits
  localparam logic [2:0] CRM_RESET_SEQ_CYC = 3'h6;
  localparam logic [2:0] CRM_PUSH_BYTES = 3'h5;
  localparam int unsigned CRM_ST_BUSY = 0;
  localparam int unsigned CRM_ST_PEND = 1;
  localparam int unsigned CRM_ST_INHIBIT = 2;
  // ==========================================================
  // Command opcodes, in command bits 7:0, operand in 23:8
  localparam logic [7:0] CRM_OP_LDA = 8'h01;
  localparam logic [7:0] CRM_OP_LDX = 8'h02;
  localparam logic [7:0] CRM_OP_LDHX = 8'h03;
  localparam logic [7:0] CRM_OP_STA = 8'h04;
  localparam logic [7:0] CRM_OP_TAX = 8'h05;
  localparam logic [7:0] CRM_OP_TXA = 8'h06;
  localparam logic [7:0] CRM_OP_CLRX = 8'h07;
  localparam logic [7:0] CRM_OP_INCX = 8'h08;
  localparam logic [7:0] CRM_OP_DECX = 8'h09;
  localparam logic [7:0] CRM_OP_COMX = 8'h0A;
  localparam logic [7:0] CRM_OP_NEGX = 8'h0B;
  localparam logic [7:0] CRM_OP_ASLX = 8'h0C;
  localparam logic [7:0] CRM_OP_LSRX = 8'h0D;
  localparam logic [7:0] CRM_OP_ROLX = 8'h0E;
  localparam logic [7:0] CRM_OP_RORX = 8'h0F;
  localparam logic [7:0] CRM_OP_ADD = 8'h10;
  localparam logic [7:0] CRM_OP_ADC = 8'h11;
  localparam logic [7:0] CRM_OP_SUB = 8'h12;
  localparam logic [7:0] CRM_OP_DEC_ADJ = 8'h13;
  localparam logic [7:0] CRM_OP_ADD_STK = 8'h14;
  localparam logic [7:0] CRM_OP_STK_LOW = 8'h15;
  localparam logic [7:0] CRM_OP_MASK_CLR = 8'h16;
  localparam logic [7:0] CRM_OP_SEI = 8'h17;
  localparam logic [7:0] CRM_OP_TAP = 8'h18;
  localparam logic [7:0] CRM_OP_JMP = 8'h19;
  localparam logic [7:0] CRM_OP_BRA = 8'h1A;
  localparam logic [7:0] CRM_OP_BLT = 8'h1B;
  localparam logic [7:0] CRM_OP_BGE = 8'h1C;
  localparam logic [7:0] CRM_OP_EA_DIR = 8'h1D;
  localparam logic [7:0] CRM_OP_EA_IX = 8'h1E;
  localparam logic [7:0] CRM_OP_EA_IX1 = 8'h1F;
  localparam logic [7:0] CRM_OP_EA_IXP = 8'h20;
  typedef enum logic [1:0] {CRM_S_RESET, CRM_S_IDLE, CRM_S_PUSH, CRM_S_VEC} crm_state_e;
endpackage : crm_pkg
`default_nettype wire

// ### testbench/crm_core_props.sv
`default_nettype none
module crm_core_props
  import crm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // Read side
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  // ==========================================================
  // Register port handshakes
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Refused places: past the last word, unaligned, or read-only
  wire rd_bad = (araddr > CRM_OFF_EA) || (araddr[1:0] != 2'h0);
  wire wr_ro = (awaddr != CRM_OFF_CMD) && (awaddr != CRM_OFF_VECTORS);
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd; arvalid && arready; endsequence
  sequence s_rd_bad; arvalid && arready && rd_bad; endsequence
  sequence s_wr_ro; awvalid && awready && wvalid && wready && wr_ro; endsequence
  sequence s_ccr; arvalid && arready && araddr == CRM_OFF_CCR; endsequence
  property p_rd_ans; s_rd |=> rvalid; endproperty
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  // Address ready comes back on the same edge that closes the read
  property p_rd_done; rvalid && rready |=> !rvalid && arready; endproperty
  property p_rd_err; s_rd_bad |=> rresp == CRM_RESP_SLVERR && rdata == 32'h0; endproperty
  property p_ccr; s_ccr |=> rdata[6:5] == 2'b11; endproperty
  property p_wr_ans; s_wr |=> !bvalid ##1 bvalid; endproperty
  property p_wr_ro; s_wr_ro |=> ##1 bresp == CRM_RESP_SLVERR; endproperty
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rd_done: assert property (p_rd_done) else $error("read close wrong");
  a_rd_err: assert property (p_rd_err) else $error("bad read accepted");
  a_ccr: assert property (p_ccr) else $error("fixed flag bits low");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer timing");
  a_wr_ro: assert property (p_wr_ro) else $error("read-only write accepted");
  a_b_hold: assert property (p_b_hold) else $error("write response moved");
  a_b_done: assert property (p_b_done) else $error("write close wrong");
endmodule : crm_core_props
bind crm_core crm_core_props #(.ADDR_W(ADDR_W)) u_crm_core_props (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
module tb
  import crm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stimulus and design
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, irq_req = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] rd_q;
  // Index-low ops in a chain; each result feeds the next
  logic [7:0] xo [10] = '{CRM_OP_LDX, CRM_OP_INCX, CRM_OP_DECX, CRM_OP_COMX, CRM_OP_NEGX,
    CRM_OP_ASLX, CRM_OP_LSRX, CRM_OP_ROLX, CRM_OP_RORX, CRM_OP_CLRX};
  logic [7:0] xe [10] = '{8'h81, 8'h82, 8'h81, 8'h7E, 8'h82, 8'h04, 8'h02, 8'h04, 8'h02, 8'h00};
  // 20 MHz clock
  always #25 aclk = ~aclk;
  crm_core u_crm_core (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .irq_req
  );
  // ==========================================================
  // Verdict, compare and bus tasks
  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (e & m)) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  // A used-up wait ends the run at once rather than hanging
  task automatic guard(input int n);
    if (n >= 100) begin
      n_mismatch++;
      $display("wrong value at %0t: no handshake", $time);
      report_and_stop();
    end
  endtask : guard
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = CRM_RESP_OKAY);
    int n;
    logic aw, w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    for (n = 0; n < 100 && !(aw && w); n++) begin
      @(posedge aclk);
      aw = aw | awready;
      w = w | wready;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    guard(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    guard(n);
    chk({30'h0, bresp}, {30'h0, er}, 32'h3);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = CRM_RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    guard(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    guard(n);
    rd_q = rdata;
    chk({30'h0, rresp}, {30'h0, er}, 32'h3);
    chk(rdata, e, m);
  endtask : rd
  // Poll until neither busy nor pending
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(CRM_OFF_STATUS, 32'h0, 32'h0);
      n++;
    end while (rd_q[1:0] !== 2'h0 && n < 100);
    guard(n);
  endtask : idle
  task automatic cmd(input logic [7:0] op, input logic [15:0] opd);
    wr(CRM_OFF_CMD, {8'h00, opd, op});
    idle();
  endtask : cmd
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CRM_OFF_STATUS, 32'h1, 32'h1);
    idle();
    rd(CRM_OFF_PC, 32'h0);
    rd(CRM_OFF_SP, 32'h00FF);
    rd(CRM_OFF_INDEX, 32'h0, 32'hFF00);
    rd(CRM_OFF_CCR, 32'h68);
    wr(CRM_OFF_ACC, 32'h55, CRM_RESP_SLVERR);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, CRM_RESP_SLVERR);
    rd(8'h05, 32'h0, 32'hFFFFFFFF, CRM_RESP_SLVERR);
    cmd(CRM_OP_LDA, 16'h0080);
    rd(CRM_OFF_CCR, 32'h04, 32'h06);
    cmd(CRM_OP_LDA, 16'h0000);
    rd(CRM_OFF_CCR, 32'h02, 32'h06);
    cmd(CRM_OP_LDHX, 16'h12FF);
    cmd(CRM_OP_EA_IXP, 16'h0000);
    rd(CRM_OFF_EA, 32'h12FF, 32'hFFFF);
    rd(CRM_OFF_INDEX, 32'h1300);
    cmd(CRM_OP_EA_DIR, 16'h0034);
    rd(CRM_OFF_EA, 32'h0034, 32'hFFFF);
    for (int i = 0; i < 10; i++) begin
      cmd(xo[i], 16'h0081);
      rd(CRM_OFF_INDEX, {24'h0, xe[i]}, 32'hFF);
      if (i == 5) rd(CRM_OFF_CCR, 32'h1, 32'h1);
    end
    cmd(CRM_OP_LDA, 16'h003C);
    cmd(CRM_OP_TAX, 16'h0000);
    rd(CRM_OFF_INDEX, 32'h3C, 32'hFF);
    cmd(CRM_OP_LDA, 16'h0078);
    cmd(CRM_OP_ADD, 16'h0008);
    rd(CRM_OFF_CCR, 32'hFC);
    cmd(CRM_OP_LDA, 16'h0019);
    cmd(CRM_OP_ADD, 16'h0028);
    cmd(CRM_OP_DEC_ADJ, 16'h0000);
    rd(CRM_OFF_ACC, 32'h47);
    cmd(CRM_OP_LDA, 16'h0010);
    cmd(CRM_OP_SUB, 16'h0020);
    rd(CRM_OFF_CCR, 32'h05, 32'h87);
    cmd(CRM_OP_JMP, 16'h4000);
    rd(CRM_OFF_PC, 32'h4000);
    cmd(CRM_OP_BGE, 16'h0010);
    cmd(CRM_OP_BLT, 16'h00F0);
    rd(CRM_OFF_PC, 32'h3FF4);
    cmd(CRM_OP_TXA, 16'h0000);
    rd(CRM_OFF_PC, 32'h3FF5);
    cmd(CRM_OP_LDA, 16'h0001);
    cmd(CRM_OP_ADC, 16'h0001);
    rd(CRM_OFF_ACC, 32'h03);
    cmd(CRM_OP_ADD_STK, 16'h00FE);
    rd(CRM_OFF_SP, 32'h00FD);
    cmd(CRM_OP_ADD_STK, 16'h0010);
    cmd(CRM_OP_STK_LOW, 16'h0000);
    rd(CRM_OFF_SP, 32'h01FF);
    // Request raised while masked: the mask must hold it off until the
    // load clears it, and then the shadow holds it for one more command
    wr(CRM_OFF_VECTORS, 32'h8000_0000);
    irq_req <= 1'b1;
    cmd(CRM_OP_TAP, 16'h0001);
    rd(CRM_OFF_CCR, 32'h61);
    repeat (8) @(posedge aclk);
    rd(CRM_OFF_STATUS, 32'h4, 32'h7);
    rd(CRM_OFF_PC, 32'h4000);
    cmd(CRM_OP_TAX, 16'h0000);
    rd(CRM_OFF_PC, 32'h8000);
    rd(CRM_OFF_CCR, 32'h69);
    rd(CRM_OFF_SP, 32'h01FA);
    rd(CRM_OFF_TRACE, 32'h0001FB61);
    irq_req <= 1'b0;
    cmd(CRM_OP_LDA, 16'h005A);
    cmd(CRM_OP_LDX, 16'h00C3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Vector written during the fetch sequence, so the load is visible
    wr(CRM_OFF_VECTORS, 32'h0000_1234);
    idle();
    rd(CRM_OFF_PC, 32'h1234);
    rd(CRM_OFF_ACC, 32'h5A);
    rd(CRM_OFF_INDEX, 32'h00C3);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
